/* File: logic/dic_pkg.sv */
// Purpose: shared constants and types of the digital input conditioner
// Assumes: 100 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   offsets are byte addresses, one aligned word per register
package dic_pkg;
  // input and function counts
  localparam int NUM_IN      = 5;
  localparam int NUM_DELAYED = 3;
  localparam int NUM_FUNC    = 53;
  localparam int FUNC_W      = 6;
  localparam int MOTOR_W     = 2;
  localparam int TIME_W      = 16;
  localparam int ADDR_W      = 8;

  // function code that picks the motor parameter set
  localparam logic [FUNC_W-1:0]  FUNC_MOTOR_SEL = 6'h29;
  // motor set forced while that input is active
  localparam logic [MOTOR_W-1:0] MOTOR_OVERRIDE = 2'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_POLARITY = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FILTER   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DELAY0   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FUNC0    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MOTOR    = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_FACT_LO  = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_FACT_HI  = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_PULSES   = 8'h38;
  localparam logic [ADDR_W-1:0] REG_STRIDE   = 8'h04;

  // field positions in the status word
  localparam int ST_COND_LSB  = 0;
  localparam int ST_SENSE_LSB = 8;
  localparam int ST_MOTOR_LSB = 16;

  // reset values
  localparam logic [NUM_IN-1:0]  POLARITY_RST = 5'h00;
  localparam logic [TIME_W-1:0]  FILTER_RST   = 16'h000A;
  localparam logic [TIME_W-1:0]  DELAY_RST    = 16'h0000;
  localparam logic [FUNC_W-1:0]  FUNC_RST     = 6'h00;
  localparam logic [MOTOR_W-1:0] MOTOR_RST    = 2'h0;

  // timing: one filter/delay tick is 1 ms
  localparam int CLK_FREQ_HZ  = 100_000_000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES  = TICK_TIME_US * (CLK_FREQ_HZ / 1_000_000);

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-input conditioned state as reported to software
  typedef struct packed {
    logic [MOTOR_W-1:0] motor;
    logic [NUM_IN-1:0]  sensed;
    logic [NUM_IN-1:0]  conditioned;
  } dic_status_t;
endpackage : dic_pkg

/* File: logic/dic_filter.sv */
// Purpose: level filter that accepts a new input level only once it has held
// Assumes: tick is a one-cycle pulse per time unit
// Notes:   a level must be seen on more than hold_ticks ticks in a row
`timescale 1ns/10ps
module dic_filter #(
  parameter int TIME_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              tick,
  input  wire logic              raw_in,
  input  wire logic [TIME_W-1:0] hold_ticks,
  output logic                   level_q
);
  logic [TIME_W:0] cnt_q, cnt_d;
  logic            level_d;

  // count ticks while the raw level differs, restart on any return
  always_comb begin
    cnt_d   = cnt_q;
    level_d = level_q;
    if (raw_in == level_q) begin
      cnt_d = '0;
    end else if (cnt_q > {1'b0, hold_ticks}) begin
      level_d = raw_in;
      cnt_d   = '0;
    end else if (tick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_filter_change: assert property ($changed(level_q) |->
    $past(raw_in) == level_q && $past(cnt_q) > {1'b0, $past(hold_ticks)})
    else $error("filtered level changed before hold time");
  chk_filter_stable: assert property ((raw_in == level_q) [*2] |=> $stable(level_q))
    else $error("filtered level moved while raw matched");
endmodule // dic_filter

/* File: logic/dic_delay.sv */
// Purpose: postpones each level change by a programmable number of ticks
// Assumes: tick is a one-cycle pulse per time unit
// Notes:   a change arriving while one is pending is taken after it ends
`timescale 1ns/10ps
module dic_delay #(
  parameter int TIME_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              tick,
  input  wire logic              in_lvl,
  input  wire logic [TIME_W-1:0] delay_ticks,
  output logic                   out_q
);
  logic [TIME_W:0] cnt_q, cnt_d;
  logic            busy_q, busy_d;
  logic            pend_q, pend_d;
  logic            out_d;

  // latch a change, wait, then pass it on
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    pend_d = pend_q;
    out_d  = out_q;
    if (!busy_q) begin
      if (in_lvl != out_q) begin
        busy_d = 1'b1;
        pend_d = in_lvl;
        cnt_d  = '0;
      end
    end else if (cnt_q > {1'b0, delay_ticks}) begin
      out_d  = pend_q;
      busy_d = 1'b0;
    end else if (tick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      pend_q <= 1'b0;
      out_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      pend_q <= pend_d;
      out_q  <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_delay_done;
    busy_q && (cnt_q > {1'b0, delay_ticks});
  endsequence
  chk_delay_release: assert property ($changed(out_q) |-> $past(busy_q) &&
    $past(cnt_q) > {1'b0, $past(delay_ticks)} && out_q == $past(pend_q))
    else $error("delayed output changed early");
  chk_delay_finish: assert property (s_delay_done |=> !busy_q && out_q == $past(pend_q))
    else $error("pending change not released");
endmodule // dic_delay

/* File: logic/dic_top.sv */
// Purpose: conditions five switch inputs and routes them to internal functions
// Assumes: inputs synchronous to aclk; AXI4-Lite slave, one transfer at a time
// Notes:   switch_input_shorted is 1 while a contact closes to common_return
`timescale 1ns/10ps
module dic_top #(
  parameter int TICK_CYCLES = dic_pkg::TICK_CYCLES
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [dic_pkg::NUM_IN-1:0]  switch_input_shorted,
  input  wire logic                        fast_pulse_input,
  input  wire logic [dic_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [dic_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [dic_pkg::NUM_IN-1:0]       conditioned_input,
  output logic [dic_pkg::NUM_FUNC-1:0]     function_active,
  output logic [dic_pkg::MOTOR_W-1:0]      motor_set_active
);
  localparam int NI = dic_pkg::NUM_IN;
  localparam int TW = dic_pkg::TIME_W;
  localparam int FW = dic_pkg::FUNC_W;
  localparam int MW = dic_pkg::MOTOR_W;
  localparam int NF = dic_pkg::NUM_FUNC;
  localparam int ADDR_W = dic_pkg::ADDR_W;

  // configuration registers
  logic [NI-1:0]                        pol_q, pol_d;
  logic [TW-1:0]                        filt_q, filt_d;
  logic [dic_pkg::NUM_DELAYED-1:0][TW-1:0] dly_q, dly_d;
  logic [NI-1:0][FW-1:0]                func_q, func_d;
  logic [MW-1:0]                        motor_q, motor_d;
  logic [31:0]                          pulses_q, pulses_d;
  logic                                 fast_q;
  // bus state
  logic                                 aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [dic_pkg::ADDR_W-1:0]           awaddr_q, awaddr_d;
  logic [31:0]                          wdata_q, wdata_d;
  logic [3:0]                           wstrb_q, wstrb_d;
  logic                                 awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]                           bresp_d, rresp_d;
  logic [31:0]                          rdata_d;
  // datapath
  logic [31:0]                          tick_cnt_q, tick_cnt_d;
  logic                                 tick_q, tick_d;
  logic [NI-1:0]                        sensed_q, filtered, cond;
  logic [NF-1:0]                        fact_d;
  logic [MW-1:0]                        mset_d;
  dic_pkg::dic_status_t                 status;
  ////////////////////////////////////////////////////////////////////////////////
  // time base: one-cycle tick every TICK_CYCLES clocks
  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 32'h0000_0000;
      tick_d     = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // per-input sense, filter and optional delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sensed_q <= '0;
    end else begin
      sensed_q <= switch_input_shorted ^ pol_q;
    end
  end
  for (genvar i = 0; i < NI; i++) begin : g_in
    dic_filter #(.TIME_W(TW)) u_filter (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .tick       (tick_q),
      .raw_in     (sensed_q[i]),
      .hold_ticks (filt_q),
      .level_q    (filtered[i])
    );
    if (i < dic_pkg::NUM_DELAYED) begin : g_dly
      dic_delay #(.TIME_W(TW)) u_delay (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .tick        (tick_q),
        .in_lvl      (filtered[i]),
        .delay_ticks (dly_q[i]),
        .out_q       (cond[i])
      );
    end else begin : g_nodly
      assign cond[i] = filtered[i];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // function routing and motor set choice
  always_comb begin
    fact_d = '0;
    mset_d = motor_q;
    for (int i = 0; i < NI; i++) begin
      if (cond[i] && func_q[i] < FW'(NF)) begin
        fact_d[func_q[i]] = 1'b1;
      end
      if (cond[i] && func_q[i] == dic_pkg::FUNC_MOTOR_SEL) begin
        mset_d = dic_pkg::MOTOR_OVERRIDE;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conditioned_input <= '0;
      function_active   <= '0;
      motor_set_active  <= dic_pkg::MOTOR_RST;
      fast_q            <= 1'b0;
    end else begin
      conditioned_input <= cond;
      function_active   <= fact_d;
      motor_set_active  <= mset_d;
      fast_q            <= fast_pulse_input;
    end
  end
  assign status.motor       = motor_set_active;
  assign status.sensed      = sensed_q;
  assign status.conditioned = conditioned_input;
  ////////////////////////////////////////////////////////////////////////////////
  // register file and AXI4-Lite slave
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  always_comb begin
    logic [31:0] m;
    logic        hit;
    m          = 32'h0000_0000;
    hit        = 1'b0;
    pol_d      = pol_q;
    filt_d     = filt_q;
    dly_d      = dly_q;
    func_d     = func_q;
    motor_d    = motor_q;
    pulses_d   = pulses_q;
    aw_have_d  = aw_have_q | (s_axi_awvalid & s_axi_awready);
    w_have_d   = w_have_q | (s_axi_wvalid & s_axi_wready);
    awaddr_d   = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_q;
    wdata_d    = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_q;
    wstrb_d    = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_q;
    bvalid_d   = s_axi_bvalid & ~s_axi_bready;
    bresp_d    = s_axi_bresp;
    // count rising edges of the dedicated fast input only
    if (fast_pulse_input && !fast_q) pulses_d = pulses_q + 32'h0000_0001;
    if (aw_have_q && w_have_q && !s_axi_bvalid) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      hit       = 1'b1;
      unique case (awaddr_q)
        dic_pkg::OFF_POLARITY: begin
          m     = merge(32'(pol_q), wdata_q, wstrb_q);
          pol_d = m[NI-1:0];
        end
        dic_pkg::OFF_FILTER: begin
          m      = merge(32'(filt_q), wdata_q, wstrb_q);
          filt_d = m[TW-1:0];
        end
        dic_pkg::OFF_MOTOR: begin
          m       = merge(32'(motor_q), wdata_q, wstrb_q);
          motor_d = m[MW-1:0];
        end
        dic_pkg::OFF_PULSES: begin
          if (!(fast_pulse_input && !fast_q)) pulses_d = 32'h0000_0000;
          else pulses_d = 32'h0000_0001; // edge in the clear cycle leaves the count at 1
        end
        default: hit = 1'b0;
      endcase
      for (int i = 0; i < dic_pkg::NUM_DELAYED; i++) begin
        if (awaddr_q == dic_pkg::OFF_DELAY0 + ADDR_W'(4 * i)) begin
          m        = merge(32'(dly_q[i]), wdata_q, wstrb_q);
          dly_d[i] = m[TW-1:0];
          hit      = 1'b1;
        end
      end
      for (int i = 0; i < NI; i++) begin
        if (awaddr_q == dic_pkg::OFF_FUNC0 + ADDR_W'(4 * i)) begin
          m         = merge(32'(func_q[i]), wdata_q, wstrb_q);
          func_d[i] = m[FW-1:0];
          hit       = 1'b1;
        end
      end
      bresp_d = hit ? dic_pkg::RESP_OKAY : dic_pkg::RESP_SLVERR;
    end
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d  = ~w_have_d & ~bvalid_d;
  end
  // read side: answer one cycle after the address is taken
  always_comb begin
    rvalid_d = s_axi_rvalid & ~s_axi_rready;
    rdata_d  = s_axi_rdata;
    rresp_d  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = dic_pkg::RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      unique case (s_axi_araddr)
        dic_pkg::OFF_POLARITY: rdata_d = 32'(pol_q);
        dic_pkg::OFF_FILTER:   rdata_d = 32'(filt_q);
        dic_pkg::OFF_MOTOR:    rdata_d = 32'(motor_q);
        dic_pkg::OFF_STATUS:   rdata_d = {14'h0000, status.motor, 3'h0, status.sensed,
                                          3'h0, status.conditioned};
        dic_pkg::OFF_FACT_LO:  rdata_d = function_active[31:0];
        dic_pkg::OFF_FACT_HI:  rdata_d = 32'(function_active[NF-1:32]);
        dic_pkg::OFF_PULSES:   rdata_d = pulses_q;
        default:               rresp_d = dic_pkg::RESP_SLVERR;
      endcase
      for (int i = 0; i < dic_pkg::NUM_DELAYED; i++) begin
        if (s_axi_araddr == dic_pkg::OFF_DELAY0 + ADDR_W'(4 * i)) begin
          rdata_d = 32'(dly_q[i]);
          rresp_d = dic_pkg::RESP_OKAY;
        end
      end
      for (int i = 0; i < NI; i++) begin
        if (s_axi_araddr == dic_pkg::OFF_FUNC0 + ADDR_W'(4 * i)) begin
          rdata_d = 32'(func_q[i]);
          rresp_d = dic_pkg::RESP_OKAY;
        end
      end
    end
    arready_d = ~rvalid_d;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_q         <= dic_pkg::POLARITY_RST;
      filt_q        <= dic_pkg::FILTER_RST;
      dly_q         <= {dic_pkg::NUM_DELAYED{dic_pkg::DELAY_RST}};
      func_q        <= {NI{dic_pkg::FUNC_RST}};
      motor_q       <= dic_pkg::MOTOR_RST;
      pulses_q      <= 32'h0000_0000;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dic_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= dic_pkg::RESP_OKAY;
    end else begin
      pol_q         <= pol_d;
      filt_q        <= filt_d;
      dly_q         <= dly_d;
      func_q        <= func_d;
      motor_q       <= motor_d;
      pulses_q      <= pulses_d;
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb_q       <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_default_sense: assert property (pol_q == 5'h00 && $past(pol_q) == 5'h00 |->
    sensed_q == $past(switch_input_shorted))
    else $error("default polarity sense wrong");
  chk_inverted_sense: assert property (pol_q[0] && $past(pol_q[0]) |->
    sensed_q[0] == !$past(switch_input_shorted[0]))
    else $error("inverted polarity sense wrong");
  chk_upper_no_delay: assert property (conditioned_input[NI-1:3] ==
    $past(filtered[NI-1:3]))
    else $error("input four or five was delayed");
  chk_route_first: assert property (cond[0] && func_q[0] < 6'h35 |=>
    function_active[$past(func_q[0])])
    else $error("active input not routed to its function");
  chk_motor_override: assert property (cond[NI-1] && func_q[NI-1] == 6'h29 |=>
    motor_set_active == dic_pkg::MOTOR_OVERRIDE)
    else $error("motor set input did not take priority");
  chk_motor_stored: assert property ((cond & ~conditioned_input) == '0 &&
    !(|(cond)) |=> motor_set_active == $past(motor_q))
    else $error("stored motor set ignored without override");
  chk_pulse_count: assert property ($rose(fast_pulse_input) && !(aw_have_q && w_have_q) |=>
    pulses_q == $past(pulses_q) + 32'h0000_0001)
    else $error("fast pulse edge not counted");
  chk_bus_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
endmodule // dic_top

/* File: sim/dic_contacts.sv */
// Purpose: switch contacts and pulse source outside the conditioner
// Assumes: commands change just after an aclk edge
// Notes:   an open contact drives its input to 0
`timescale 1ns/10ps
module dic_contacts (
  input  wire logic       aclk,
  input  wire logic [4:0] close_cmd,
  input  wire logic       pulse_cmd,
  output logic      [4:0] shorted,
  output logic            fast_pulse
);
  // each contact closes its own input to common return
  always_ff @(posedge aclk) begin
    shorted <= close_cmd;
  end
  // pulse trains reach the fast input only
  always_ff @(posedge aclk) begin
    fast_pulse <= pulse_cmd;
  end
endmodule // dic_contacts

/* File: sim/testbench.sv */
// Purpose: self-checking bench of the input conditioner
// Assumes: tick shortened to 4 clocks
// Notes:   registers reached by AXI4-Lite tasks
`timescale 1ns/10ps
`define CMP(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) begin \
      error_cnt++; \
      $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); \
    end \
  end
module testbench;
  localparam int TK = 4;
  logic                         aclk;
  logic                         aresetn;
  logic [4:0]                   close_cmd, shorted, cond;
  logic                         pulse_cmd, fast_pulse;
  logic [7:0]                   awaddr, araddr;
  logic [31:0]                  wdata, rdata, rd;
  logic [3:0]                   wstrb;
  logic                         awvalid, awready, wvalid, wready, bvalid, bready;
  logic                         arvalid, arready, rvalid, rready;
  logic [1:0]                   bresp, rresp, resp;
  logic [dic_pkg::NUM_FUNC-1:0] fact;
  logic [dic_pkg::MOTOR_W-1:0]  motor;
  int                           error_cnt = 0;
  int                           checked = 0;

  ////////////////////////////////////////////////////////////////////////////////
  dic_top #(.TICK_CYCLES(TK)) dut (
    .aclk(aclk), .aresetn(aresetn), .switch_input_shorted(shorted),
    .fast_pulse_input(fast_pulse), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conditioned_input(cond), .function_active(fact), .motor_set_active(motor));
  dic_contacts sw (.aclk(aclk), .close_cmd(close_cmd), .pulse_cmd(pulse_cmd),
    .shorted(shorted), .fast_pulse(fast_pulse));

  // clock of 10 ns
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // closing report
  task automatic print_verdict();
    $display("counts checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // register write, held until each channel is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 60) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  // register read
  task automatic rd_reg(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n == 60) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  // read and compare with an okay response
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a);
    `CMP({resp, rd}, {dic_pkg::RESP_OKAY, e})
  endtask
  // wait for masked conditioned inputs, counting clocks
  task automatic wait_cond(input logic [4:0] m, input logic [4:0] e, output int c);
    for (c = 0; c < 400; c++) begin
      @(posedge aclk);
      if ((cond & m) === e) break;
    end
    if (c == 400) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reset values, unmapped and read-only places
  task automatic t_regs();
    chk_rd(dic_pkg::OFF_POLARITY, 32'h00000000);
    chk_rd(dic_pkg::OFF_FILTER, 32'h0000000A);
    chk_rd(dic_pkg::OFF_DELAY0, 32'h00000000);
    chk_rd(dic_pkg::OFF_FUNC0, 32'h00000000);
    chk_rd(dic_pkg::OFF_MOTOR, 32'h00000000);
    rd_reg(8'h3C);
    `CMP({resp, rd}, {dic_pkg::RESP_SLVERR, 32'h00000000}) // unmapped
    wr(dic_pkg::OFF_STATUS, 32'h0000001F);
    `CMP(resp, dic_pkg::RESP_SLVERR) // read-only
    $display("test regs done");
  endtask
  // polarity per input
  task automatic t_pol();
    int c;
    wr(dic_pkg::OFF_FILTER, 32'h00000001);
    close_cmd <= 5'h01;
    wait_cond(5'h1F, 5'h01, c);
    `CMP(cond, 5'h01)
    wr(dic_pkg::OFF_POLARITY, 32'h00000015);
    wait_cond(5'h1F, 5'h14, c);
    `CMP(cond, 5'h14)
    rd_reg(dic_pkg::OFF_STATUS);
    `CMP(rd[12:8], 5'h14)
    wr(dic_pkg::OFF_POLARITY, 32'h00000000);
    close_cmd <= 5'h00;
    wait_cond(5'h1F, 5'h00, c);
    $display("test polarity done");
  endtask
  // glitch rejected, held level accepted after the filter time
  task automatic t_filter();
    int c;
    logic seen = 1'b0;
    wr(dic_pkg::OFF_FILTER, 32'h00000003);
    close_cmd <= 5'h08;
    repeat (TK) @(posedge aclk);
    close_cmd <= 5'h00;
    for (c = 0; c < 8 * TK; c++) begin
      @(posedge aclk);
      seen |= cond[3];
    end
    `CMP(seen, 1'b0)
    close_cmd <= 5'h08;
    wait_cond(5'h08, 5'h08, c);
    `CMP(c >= 3 * TK && c <= 6 * TK, 1'b1)
    close_cmd <= 5'h00;
    wait_cond(5'h08, 5'h00, c);
    $display("test filter done");
  endtask
  // delayed first input against undelayed fourth
  task automatic t_delay();
    int c;
    int d;
    wr(dic_pkg::OFF_FILTER, 32'h00000001);
    wr(dic_pkg::OFF_DELAY0, 32'h00000005);
    close_cmd <= 5'h09;
    wait_cond(5'h08, 5'h08, c);
    wait_cond(5'h01, 5'h01, d);
    `CMP(d >= 4 * TK && d <= 8 * TK, 1'b1)
    wr(dic_pkg::OFF_DELAY0, 32'h00000000);
    close_cmd <= 5'h00;
    wait_cond(5'h1F, 5'h00, c);
    $display("test delay done");
  endtask
  // fifth input through every function code, motor set override
  task automatic t_route();
    int c;
    int f;
    logic [dic_pkg::NUM_FUNC-1:0] e;
    wr(dic_pkg::OFF_MOTOR, 32'h00000002);
    close_cmd <= 5'h10;
    wait_cond(5'h10, 5'h10, c);
    for (f = 0; f <= dic_pkg::NUM_FUNC; f++) begin
      e = '0;
      if (f < dic_pkg::NUM_FUNC) e[f] = 1'b1;
      wr(dic_pkg::OFF_FUNC0 + 8'h10, 32'(f));
      for (c = 0; c < 20 && fact !== e; c++) @(posedge aclk);
      `CMP(fact, e)
      `CMP(motor, (f == 41) ? dic_pkg::MOTOR_OVERRIDE : 2'h2)
      if (f == 0) chk_rd(dic_pkg::OFF_FACT_LO, 32'h00000001);
      if (f == 41) chk_rd(dic_pkg::OFF_FACT_HI, 32'h00000200);
      if (f == 41) chk_rd(dic_pkg::OFF_STATUS, 32'h00011010);
    end
    close_cmd <= 5'h00;
    wait_cond(5'h10, 5'h00, c);
    $display("test route done");
  endtask
  // pulses counted on the fast input only
  task automatic t_pulse();
    int i;
    wr(dic_pkg::OFF_PULSES, 32'h00000000);
    for (i = 0; i < 7; i++) begin
      @(posedge aclk);
      pulse_cmd <= 1'b1;
      @(posedge aclk);
      pulse_cmd <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    chk_rd(dic_pkg::OFF_PULSES, 32'h00000007);
    `CMP(cond, 5'h00)
    $display("test pulse done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reset for 20 clocks, then the scenarios
  initial begin
    aresetn = 1'b0;
    {close_cmd, pulse_cmd, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_pol();
    t_filter();
    t_delay();
    t_route();
    t_pulse();
    print_verdict();
  end
endmodule // testbench
